// ---- core/ltpc_pkg.sv ----
package ltpc_pkg;
    // Device register addresses on the serial link.
    localparam logic [7:0] LTPC_ADR_MODE = 8'h25;
    localparam logic [7:0] LTPC_ADR_CODE1 = 8'h26;
    localparam logic [7:0] LTPC_ADR_CODE2 = 8'h27;
    localparam logic [7:0] LTPC_ADR_SNR = 8'h43;
    localparam logic [7:0] LTPC_ADR_DITHER = 8'h01;
    // Field positions.
    localparam int LTPC_DUAL_BIT = 5;
    localparam int LTPC_FIXED_BIT = 4;
    localparam int LTPC_C2_MSB_HI = 3;
    localparam int LTPC_C2_MSB_LO = 2;
    localparam int LTPC_C1_MSB_HI = 1;
    localparam int LTPC_C1_MSB_LO = 0;
    localparam int LTPC_LOW_HI = 15;
    localparam int LTPC_LOW_LO = 6;
    localparam int LTPC_SNR_BIT = 0;
    localparam int LTPC_DITHER_BIT = 0;
    // Reset values.
    localparam logic [15:0] LTPC_MODE_RST = 16'h0000;
    localparam logic [15:0] LTPC_CODE_RST = 16'h0000;
    localparam logic [15:0] LTPC_SNR_RST = 16'h8001;
    localparam logic [15:0] LTPC_DITHER_RST = 16'h0001;
    // Widths and timing counts.
    localparam int LTPC_CODE_W = 12;
    localparam int LTPC_FRAME_BITS = 24;
    localparam logic [4:0] LTPC_PHASE_LAST = 5'h17;
    localparam logic [4:0] LTPC_SMP_HALF = 5'h18;
    localparam logic [3:0] LTPC_SCLK_HALF = 4'h8;
    // Host register byte addresses on the Wishbone bus.
    localparam logic [7:0] LTPC_HADR_CTRL = 8'h00;
    localparam logic [7:0] LTPC_HADR_CMD = 8'h04;
    localparam logic [7:0] LTPC_HADR_STAT = 8'h08;
    localparam logic [7:0] LTPC_HADR_RX = 8'h0c;
    localparam int LTPC_CTRL_PD_BIT = 0;
    localparam int LTPC_STAT_BUSY_BIT = 0;
endpackage

// ---- core/ltpc_if.sv ----
`timescale 1ns/10ps
// Wires between the host controller and the converter output logic.
interface ltpc_if;
    logic link_clk;
    logic sample_clock_in_pos;
    logic serial_clk;
    logic serial_enable_n;
    logic serial_data;
    logic powerdown_pin;
    logic bit_clock_out_pos;
    logic bit_clock_out_neg;
    logic data_out;
    logic frame_out;
    modport host (
        output link_clk, sample_clock_in_pos, serial_clk, serial_enable_n,
        output serial_data, powerdown_pin,
        input bit_clock_out_pos, bit_clock_out_neg, data_out, frame_out
    );
    modport device (
        input link_clk, sample_clock_in_pos, serial_clk, serial_enable_n,
        input serial_data, powerdown_pin,
        output bit_clock_out_pos, bit_clock_out_neg, data_out, frame_out
    );
endinterface

// ---- core/ltpc_device.sv ----
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
// Functional notes
// RL1 - Dual enable alone toggles first, second code.
// RL2 - Fixed enable alone sends first code.
// RL3 - First code: MSBs 0x25 D1:D0, low 0x26.
// RL4 - First code low bits in D15:D6.
// RL5 - Second code: low 0x27, MSBs 0x25 D3:D2.
// RL6 - SNR enhancement bit, on by default.
// RL7 - Dither on after reset, cleared by write.
// RL8 - Bit clock falls first after sample edge.
// RL9 - Power-down pin stops the whole output.
// RL10 - Receiver tolerates whole-sample alignment shifts.
// RL11 - No pattern enable sends converted samples.
module ltpc_device
    import ltpc_pkg::*;
(
    // Link to the host.
    ltpc_if.device lnk,
    // Reset.
    input wire logic RST_N_IN,
    // Converter core.
    input wire logic [LTPC_CODE_W-1:0] SAMPLE_DATA_IN,
    // Status of the analog controls.
    output logic DITHER_EN_OUT,
    output logic SNR_EN_OUT,
    output logic POWERED_DOWN_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    // Synchroniser order: serial clock, enable, data, sample clock, pd.
    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic sclk_d;
        logic smp_d;
        logic [4:0] bitcnt;
        logic [23:0] shreg;
        logic [15:0] mode;
        logic [15:0] code1lo;
        logic [15:0] code2lo;
        logic [15:0] snr;
        logic [15:0] dither;
        logic [4:0] phase;
        logic sel2;
        logic [LTPC_CODE_W-1:0] word;
        logic bclk;
        logic bclk_n;
        logic dout;
        logic frame;
    } ltpc_dev_s;

    ltpc_dev_s r;
    ltpc_dev_s next_r;

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    // All link-facing logic runs on the link clock; pins from the host
    // are resynchronised because the host drives them from its own clock.
    always_comb begin
        logic sclk;
        logic sen_n;
        logic sdat;
        logic smp;
        logic pd;
        logic [23:0] wr_word;
        logic [4:0] ph;
        logic [3:0] idx;
        logic dual;
        logic fixed;
        logic [LTPC_CODE_W-1:0] code1;
        logic [LTPC_CODE_W-1:0] code2;
        next_r = r;
        sclk = r.sync2[4];
        sen_n = r.sync2[3];
        sdat = r.sync2[2];
        smp = r.sync2[1];
        pd = r.sync2[0];
        wr_word = {r.shreg[22:0], sdat};
        ph = 5'h00;
        idx = 4'h0;
        next_r.sync1 = {lnk.serial_clk, lnk.serial_enable_n, lnk.serial_data,
                        lnk.sample_clock_in_pos, lnk.powerdown_pin};
        next_r.sync2 = r.sync1;
        next_r.sclk_d = sclk;
        next_r.smp_d = smp;

        // Serial write: 8 address bits then 16 data bits, MSB first,
        // taken on the rising serial clock while enable is low.
        if (sen_n) begin
            next_r.bitcnt = 5'h00;
        end else if (sclk && !r.sclk_d && r.bitcnt != 5'(LTPC_FRAME_BITS)) begin
            next_r.shreg = wr_word;
            next_r.bitcnt = r.bitcnt + 5'h01;
            if (r.bitcnt == 5'(LTPC_FRAME_BITS - 1)) begin
                unique case (wr_word[23:16])
                    LTPC_ADR_MODE: begin
                        next_r.mode = wr_word[15:0];
                    end
                    LTPC_ADR_CODE1: begin
                        next_r.code1lo = wr_word[15:0];
                    end
                    LTPC_ADR_CODE2: begin
                        next_r.code2lo = wr_word[15:0];
                    end
                    // RL6 SNR mode write.
                    LTPC_ADR_SNR: begin
                        next_r.snr = wr_word[15:0];
                    end
                    // RL7 dither clear write.
                    LTPC_ADR_DITHER: begin
                        next_r.dither = wr_word[15:0];
                    end
                    default: begin
                        next_r.shreg = wr_word;
                    end
                endcase
            end
        end

        // RL3 first code assembly.
        // RL4 low bits upper positions.
        code1 = {r.mode[LTPC_C1_MSB_HI:LTPC_C1_MSB_LO],
                 r.code1lo[LTPC_LOW_HI:LTPC_LOW_LO]};
        // RL5 second code assembly.
        code2 = {r.mode[LTPC_C2_MSB_HI:LTPC_C2_MSB_LO],
                 r.code2lo[LTPC_LOW_HI:LTPC_LOW_LO]};
        dual = r.mode[LTPC_DUAL_BIT] && !r.mode[LTPC_FIXED_BIT];
        fixed = r.mode[LTPC_FIXED_BIT] && !r.mode[LTPC_DUAL_BIT];

        // RL9 full power-down.
        if (pd) begin
            next_r.phase = LTPC_PHASE_LAST;
            next_r.bclk = 1'b0;
            next_r.bclk_n = 1'b1;
            next_r.dout = 1'b0;
            next_r.frame = 1'b0;
            next_r.sel2 = 1'b0;
        end else if (smp && !r.smp_d) begin
            // A new sample starts at each rising sample clock.
            if (dual) begin
                // RL1 alternate two codes.
                next_r.word = r.sel2 ? code2 : code1;
                next_r.sel2 = !r.sel2;
            end else if (fixed) begin
                // RL2 constant first code.
                next_r.word = code1;
                next_r.sel2 = 1'b0;
            end else begin
                // RL11 normal sample data.
                next_r.word = SAMPLE_DATA_IN;
                next_r.sel2 = 1'b0;
            end
            next_r.phase = 5'h00;
            // RL8 start high, fall next.
            next_r.bclk = 1'b1;
            next_r.bclk_n = 1'b0;
            next_r.dout = next_r.word[LTPC_CODE_W-1];
            next_r.frame = 1'b1;
        end else if (r.phase != LTPC_PHASE_LAST) begin
            // Each bit spans two link cycles; the bit clock toggles every
            // cycle, so the data sits still across its falling edge.
            ph = r.phase + 5'h01;
            idx = 4'(LTPC_CODE_W - 1) - 4'(ph >> 1);
            next_r.phase = ph;
            // RL8 toggling bit clock.
            next_r.bclk = !r.bclk;
            next_r.bclk_n = r.bclk;
            next_r.dout = r.word[idx];
            next_r.frame = ph < 5'(LTPC_CODE_W);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    // Register file keeps its contents through power-down; only reset
    // brings back the defaults.
    always_ff @(posedge lnk.link_clk or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            r <= '0;
            r.sync1 <= 5'h08;
            r.sync2 <= 5'h08;
            r.mode <= LTPC_MODE_RST;
            r.code1lo <= LTPC_CODE_RST;
            r.code2lo <= LTPC_CODE_RST;
            r.snr <= LTPC_SNR_RST;
            r.dither <= LTPC_DITHER_RST;
            r.phase <= LTPC_PHASE_LAST;
            r.bclk_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Every output is a plain flip-flop copy.
    assign lnk.bit_clock_out_pos = r.bclk;
    assign lnk.bit_clock_out_neg = r.bclk_n;
    assign lnk.data_out = r.dout;
    assign lnk.frame_out = r.frame;
    assign DITHER_EN_OUT = r.dither[LTPC_DITHER_BIT];
    assign SNR_EN_OUT = r.snr[LTPC_SNR_BIT];
    assign POWERED_DOWN_OUT = r.sync2[0];

endmodule

// ---- core/ltpc_host.sv ----
`timescale 1ns/10ps
module ltpc_host
    import ltpc_pkg::*;
(
    // Clock and reset.
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    // Wishbone slave.
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [31:0] WB_DAT_IN,
    input wire logic [3:0] WB_SEL_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    // Link to the converter.
    ltpc_if.host lnk
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    // Synchroniser order: bit clock, data, frame.
    typedef struct packed {
        logic lclk;
        logic smp;
        logic [4:0] smpcnt;
        logic sclk;
        logic sen_n;
        logic [3:0] divcnt;
        logic [4:0] bitcnt;
        logic [23:0] shreg;
        logic busy;
        logic pd;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic bclk_d;
        logic frame_d;
        logic [LTPC_CODE_W-1:0] rxsh;
        logic [LTPC_CODE_W-1:0] rxword;
        logic ack;
        logic [31:0] rdat;
    } ltpc_host_s;

    ltpc_host_s r;
    ltpc_host_s next_r;

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic req;
        logic wr;
        logic bclk;
        logic frame;
        next_r = r;
        req = WB_CYC_IN && WB_STB_IN && !r.ack;
        wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && r.ack;
        bclk = r.sync2[2];
        frame = r.sync2[0];

        // Link clock is half the reference; the sample clock spans 24
        // link cycles, one per serialised bit clock phase.
        next_r.lclk = !r.lclk;
        if (r.smpcnt == LTPC_SMP_HALF - 5'h01) begin
            next_r.smpcnt = 5'h00;
            next_r.smp = !r.smp;
        end else begin
            next_r.smpcnt = r.smpcnt + 5'h01;
        end

        // Wishbone: answer one cycle after the request, drop it next.
        // A write lands on the edge that shows ack to the master, so a
        // master that walks away early leaves no half-taken command.
        next_r.ack = req;
        next_r.rdat = 32'h0000_0000;
        if (wr) begin
            if (WB_ADR_IN == LTPC_HADR_CTRL && WB_SEL_IN[0]) begin
                // RL9 host drives power-down.
                next_r.pd = WB_DAT_IN[LTPC_CTRL_PD_BIT];
            end
            if (WB_ADR_IN == LTPC_HADR_CMD && &WB_SEL_IN[2:0] && !r.busy) begin
                next_r.shreg = WB_DAT_IN[23:0];
                next_r.busy = 1'b1;
                next_r.sen_n = 1'b0;
                next_r.sclk = 1'b0;
                next_r.bitcnt = 5'h00;
                next_r.divcnt = 4'h0;
            end
        end else if (req && !WB_WE_IN) begin
            unique case (WB_ADR_IN)
                LTPC_HADR_CTRL: next_r.rdat[LTPC_CTRL_PD_BIT] = r.pd;
                LTPC_HADR_STAT: next_r.rdat[LTPC_STAT_BUSY_BIT] = r.busy;
                LTPC_HADR_RX: next_r.rdat[LTPC_CODE_W-1:0] = r.rxword;
                default: next_r.rdat = 32'h0000_0000;
            endcase
        end

        // Serial write engine; data changes on the falling serial clock
        // so it is stable long before the device resamples it.
        if (r.busy) begin
            if (r.divcnt == LTPC_SCLK_HALF - 4'h1) begin
                next_r.divcnt = 4'h0;
                if (r.bitcnt == 5'(LTPC_FRAME_BITS)) begin
                    next_r.busy = 1'b0;
                end else if (!r.sclk) begin
                    next_r.sclk = 1'b1;
                end else begin
                    next_r.sclk = 1'b0;
                    next_r.bitcnt = r.bitcnt + 5'h01;
                    next_r.shreg = {r.shreg[22:0], 1'b0};
                    if (r.bitcnt == 5'(LTPC_FRAME_BITS - 1)) begin
                        next_r.sen_n = 1'b1;
                    end
                end
            end else begin
                next_r.divcnt = r.divcnt + 4'h1;
            end
        end

        // RL10 frame-aligned capture.
        next_r.sync1 = {lnk.bit_clock_out_pos, lnk.data_out, lnk.frame_out};
        next_r.sync2 = r.sync1;
        next_r.bclk_d = bclk;
        next_r.frame_d = frame;
        if (!bclk && r.bclk_d) begin
            next_r.rxsh = {r.rxsh[LTPC_CODE_W-2:0], r.sync2[1]};
        end
        if (frame && !r.frame_d) begin
            next_r.rxword = r.rxsh;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            r <= '0;
            r.sen_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign WB_DAT_OUT = r.rdat;
    assign WB_ACK_OUT = r.ack;
    assign lnk.link_clk = r.lclk;
    assign lnk.sample_clock_in_pos = r.smp;
    assign lnk.serial_clk = r.sclk;
    assign lnk.serial_enable_n = r.sen_n;
    assign lnk.serial_data = r.shreg[23];
    assign lnk.powerdown_pin = r.pd;

endmodule

// ---- sim/ltpc_assertions.sv ----
`timescale 1ns/10ps
// Watches the link; serial side on the reference clock, stream on the link clock.
module ltpc_assertions (
    // Clocks and reset.
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic link_clk,
    // Host to device.
    input wire logic serial_clk,
    input wire logic serial_enable_n,
    input wire logic serial_data,
    input wire logic powerdown_pin,
    // Device to host.
    input wire logic bit_clock_out_pos,
    input wire logic bit_clock_out_neg,
    input wire logic data_out,
    input wire logic frame_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // Serial frames: a low phase of eight cycles leads, so the device never sees a short bit.
    sen_start_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        $fell(serial_enable_n) |-> !serial_clk [*8] ##1 serial_clk)
        else $error("serial clock low phase wrong at frame start");
    sclk_high_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        $rose(serial_clk) |-> serial_clk [*8] ##1 !serial_clk)
        else $error("serial clock high phase wrong");
    sclk_idle_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        serial_enable_n |-> !serial_clk)
        else $error("serial clock runs outside a frame");
    sdata_edge_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        $changed(serial_data) && !serial_enable_n && !$past(serial_enable_n)
        |-> $fell(serial_clk))
        else $error("serial data moved away from a falling clock");
    ////////////////////////////////////////////////////////////////////////////////
    // Output stream.
    bclk_pair_a: assert property (@(posedge link_clk) disable iff (!RST_N_IN)
        bit_clock_out_neg != bit_clock_out_pos)
        else $error("bit clock pair not complementary");
    // Power-down may legally cut a sample short, so the frame shape checks stand aside then.
    bclk_first_a: assert property (@(posedge link_clk)
        disable iff (!RST_N_IN || powerdown_pin)
        $rose(frame_out) |-> bit_clock_out_pos ##1 !bit_clock_out_pos ##1 bit_clock_out_pos)
        else $error("bit clock does not fall first after sample start");
    frame_len_a: assert property (@(posedge link_clk)
        disable iff (!RST_N_IN || powerdown_pin)
        $rose(frame_out) |-> frame_out [*8] ##1 frame_out [*4] ##1 !frame_out)
        else $error("frame marker not twelve cycles long");
    bit_pairs_a: assert property (@(posedge link_clk)
        disable iff (!RST_N_IN || powerdown_pin)
        $rose(frame_out) |-> ##1 $stable(data_out) ##2 $stable(data_out))
        else $error("data bit not held for two cycles");
    pd_quiet_a: assert property (@(posedge link_clk) disable iff (!RST_N_IN)
        powerdown_pin [*5] |-> !bit_clock_out_pos && !frame_out && !data_out)
        else $error("output active while powered down");
endmodule

// ---- sim/lvds_test_pattern_config_tb.sv ----
`timescale 1ns/10ps
module lvds_test_pattern_config_tb;
    import ltpc_pkg::*;
    logic ref_clk = 1'b0;
    // Starts high so that the drop at time zero is a real edge for both ends.
    logic rst_n = 1'b1;
    logic cyc = 1'b0, we = 1'b0, rd_chk = 1'b0, armed = 1'b0, frm_d = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdata, wb_rd;
    logic [11:0] smp = 12'h000, c1, c2, word;
    logic [15:0] seed = 16'h005d;
    logic [1:0] b;
    logic wb_ack;
    wire logic [2:0] st;
    int n_mismatch = 0, total_checks = 0, nwords = 0, k = 24, t;
    logic [31:0] exp_q[$];
    logic [11:0] word_q[$];
    ltpc_if lnk_if();
    ////////////////////////////////////////////////////////////////////////////////
    // Reference clock of 4 ns.
    always #2 ref_clk = ~ref_clk;
    ltpc_host ltpc_host_i (.REF_CLK_IN(ref_clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc),
        .WB_STB_IN(cyc), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_DAT_IN(dat), .WB_SEL_IN(4'hf),
        .WB_DAT_OUT(wb_rd), .WB_ACK_OUT(wb_ack), .lnk(lnk_if.host));
    ltpc_device ltpc_device_i (.lnk(lnk_if.device), .RST_N_IN(rst_n), .SAMPLE_DATA_IN(smp),
        .DITHER_EN_OUT(st[0]), .SNR_EN_OUT(st[1]), .POWERED_DOWN_OUT(st[2]));
    ltpc_assertions ltpc_assertions_i (.REF_CLK_IN(ref_clk), .RST_N_IN(rst_n),
        .link_clk(lnk_if.link_clk), .serial_clk(lnk_if.serial_clk),
        .serial_enable_n(lnk_if.serial_enable_n), .serial_data(lnk_if.serial_data),
        .powerdown_pin(lnk_if.powerdown_pin), .bit_clock_out_pos(lnk_if.bit_clock_out_pos),
        .bit_clock_out_neg(lnk_if.bit_clock_out_neg), .data_out(lnk_if.data_out),
        .frame_out(lnk_if.frame_out));
    ////////////////////////////////////////////////////////////////////////////////
    // Automatic, since both watchers may compare in one time step.
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task timeout(input string what);
        n_mismatch++;
        $display("FAIL %s expected done seen timeout", what);
        complete_run();
    endtask
    // One classic cycle; ack is sampled at the edge, then the request is released.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
        int i;
        @(posedge ref_clk);
        rd_chk = c;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        for (i = 0; i < 50 && wb_ack !== 1'b1; i++) @(posedge ref_clk);
        if (i == 50) timeout("ack");
        rdata = wb_rd;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0, 1'b1);
    endtask
    // The controller drops commands while busy, so each write waits it out.
    task dev_wr(input logic [7:0] a, input logic [15:0] d);
        int i;
        wb(1'b1, LTPC_HADR_CMD, {8'h00, a, d}, 1'b0);
        for (i = 0; i < 300; i++) begin
            wb(1'b0, LTPC_HADR_STAT, 32'h0, 1'b0);
            if (rdata[LTPC_STAT_BUSY_BIT] === 1'b0) break;
        end
        if (i == 300) timeout("busy");
    endtask
    task wait_words(input int n);
        int i, s;
        s = nwords;
        for (i = 0; i < 5000 && nwords < s + n; i++) @(posedge ref_clk);
        if (i == 5000) timeout("words");
    endtask
    task wait_st(input int x, input logic v, input string what);
        int i;
        for (i = 0; i < 2000 && st[x] !== v; i++) @(posedge ref_clk);
        if (i == 2000) timeout(what);
        chk(what, {31'h0, v}, {31'h0, st[x]});
    endtask
    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task codes();
        seed = lfsr(seed);
        c1 = seed[11:0];
        seed = lfsr(seed);
        c2 = {~c1[11], seed[10:0]};
        smp <= seed[15:4];
        dev_wr(LTPC_ADR_CODE1, {c1[9:0], 6'h00});
        dev_wr(LTPC_ADR_CODE2, {c2[9:0], 6'h00});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Read results are compared against the oldest note.
    always @(posedge ref_clk) begin
        if (wb_ack === 1'b1 && !we && rd_chk && exp_q.size() > 0) begin
            chk("wb read", exp_q.pop_front(), wb_rd);
        end
    end
    // Assembles one word a frame, bit 11 first, two link cycles a bit.
    always @(posedge lnk_if.link_clk) begin
        if (lnk_if.frame_out && !frm_d) k = 0;
        else if (k < 24) k++;
        frm_d = lnk_if.frame_out;
        if (st[2] === 1'b1) k = 24;
        if (k == 1) chk("bclk fall", 32'h0, {31'h0, lnk_if.bit_clock_out_pos});
        if (k == 12) chk("frame end", 32'h0, {31'h0, lnk_if.frame_out});
        if (k < 24 && k % 2 == 0) word[11 - k / 2] = lnk_if.data_out;
        if (k == 22) begin
            nwords++;
            // Words seen while armed take the oldest note; a missing note is a mismatch.
            if (armed && word_q.size() == 0) begin
                chk("word note", 32'h0, 32'h1);
            end else if (armed) begin
                chk("word", 32'(word_q.pop_front()), 32'(word));
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_st(0, 1'b1, "dither at reset");
        wait_st(1, 1'b1, "snr at reset");
        rd(8'h10, 32'h0);
        $display("reset test done");
        // Normal data, fixed code, and both enables set.
        for (t = 0; t < 3; t++) begin
            codes();
            b = (t == 0) ? 2'b00 : ((t == 1) ? 2'b01 : 2'b11);
            dev_wr(LTPC_ADR_MODE, {10'h000, b, c2[11:10], c1[11:10]});
            wait_words(3);
            repeat (4) word_q.push_back((b == 2'b01) ? c1 : smp);
            armed = 1'b1;
            wait_words(4);
            armed = 1'b0;
            if (b == 2'b01) rd(LTPC_HADR_RX, {20'h00000, c1});
            $display("pattern test %0d done", t);
        end
        // Toggle started from power-down, so the first code is known.
        codes();
        dev_wr(LTPC_ADR_MODE, {10'h000, 2'b10, c2[11:10], c1[11:10]});
        wb(1'b1, LTPC_HADR_CTRL, 32'h1, 1'b0);
        wait_st(2, 1'b1, "powered down");
        rd(LTPC_HADR_CTRL, 32'h1);
        repeat (3) begin
            word_q.push_back(c1);
            word_q.push_back(c2);
        end
        armed = 1'b1;
        wb(1'b1, LTPC_HADR_CTRL, 32'h0, 1'b0);
        wait_st(2, 1'b0, "powered up");
        wait_words(6);
        armed = 1'b0;
        $display("toggle test done");
        dev_wr(LTPC_ADR_DITHER, 16'h0000);
        wait_st(0, 1'b0, "dither off");
        dev_wr(LTPC_ADR_SNR, 16'h0000);
        wait_st(1, 1'b0, "snr off");
        dev_wr(LTPC_ADR_SNR, 16'h8001);
        wait_st(1, 1'b1, "snr on");
        $display("control test done");
        complete_run();
    end
endmodule
